// ---- verilog/mctc_map.svh ----
// offsets, field positions, reset values and divider counts of the clock tree control
// assumes inclusion by bare name from the top module and the property checker
`ifndef MCTC_MAP_SVH
`define MCTC_MAP_SVH

// ****************************************
// register offsets and reset values
// ****************************************
`define MCTC_REG_PWR_DIV 7'h04
`define MCTC_REG_OUT_CLK 7'h07
`define MCTC_PWR_DIV_RST 8'h00
`define MCTC_OUT_CLK_RST 8'h00

// ****************************************
// field positions
// ****************************************
`define MCTC_MDIV_MSB 1
`define MCTC_MDIV_LSB 0
`define MCTC_PWR_MSB 5
`define MCTC_PWR_LSB 4
`define MCTC_ODIV_MSB 1
`define MCTC_ODIV_LSB 0
`define MCTC_APPLIED_BIT 7

// ****************************************
// divider periods, stored as period minus one; then channel count and decimation log2 limits
// ****************************************
`define MCTC_PER_DIV1 5'h00
`define MCTC_PER_DIV2 5'h01
`define MCTC_PER_DIV4 5'h03
`define MCTC_PER_DIV8 5'h07
`define MCTC_PER_DIV32 5'h1F
`define MCTC_NUM_CH 8
`define MCTC_DEC_MIN 4'h5
`define MCTC_DEC_MAX 4'hA

`endif

// ---- verilog/mctc_pkg.sv ----
// types shared by the clock tree control modules
// assumes the map header sits on the include path
package mctc_pkg;
  typedef enum logic [1:0] {
    MCTC_PWR_LOW = 2'h0,
    MCTC_PWR_MED = 2'h1,
    MCTC_PWR_FAST = 2'h2,
    MCTC_PWR_RSVD = 2'h3
  } mctc_pwr_e;
  typedef logic [4:0] mctc_per_t;
  typedef logic [1:0] mctc_code_t;
  typedef struct packed {
    mctc_pwr_e pwr;
    mctc_code_t mdiv;
    mctc_code_t odiv;
  } mctc_cfg_s;
endpackage : mctc_pkg

// ---- verilog/mctc_clk_if.sv ----
// divided clock as seen by its users: level, edge pulses and the setting it runs with
// assumes one clock domain shared by source and sink
`timescale 1ns/1ps
interface mctc_clk_if;
  logic lvl;
  logic rise;
  logic fall;
  logic [1:0] tag;
  modport src (output lvl, output rise, output fall, output tag);
  modport snk (input lvl, input rise, input fall, input tag);
endinterface : mctc_clk_if

// ---- verilog/mctc_div.sv ----
// programmable divider of the master clock with a setting tag
// assumes period and tag inputs are stable in the wrap cycle
`timescale 1ns/1ps
module mctc_div import mctc_pkg::*; #(
  parameter mctc_per_t RST_PER = 5'h00
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requested setting
  input wire mctc_per_t per_in,
  input wire logic [1:0] tag_in,
  // divided clock
  mctc_clk_if.src out
);
  mctc_per_t cnt, next_cnt, per, next_per, half;
  logic [1:0] tag, next_tag;
  logic lvl, next_lvl, rise, next_rise, fall, next_fall;

  // new settings only take hold at a period boundary, so no runt pulse
  always_comb begin
    next_cnt = (cnt == per) ? 5'h00 : 5'(cnt + 5'h01);
    next_per = (cnt == per) ? per_in : per;
    next_tag = (cnt == per) ? tag_in : tag;
    half = 5'((6'(next_per) + 6'h01) >> 1);
    next_rise = (next_cnt == 5'h00);
    next_fall = (next_per != 5'h00) && (next_cnt == half);
    // period of one cycle: level cannot toggle faster, holds high
    next_lvl = (next_per == 5'h00) || (next_cnt < half);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // start on the wrap: the first period opens with its rise pulse
      cnt <= RST_PER;
      per <= RST_PER;
      tag <= 2'h0;
      lvl <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      cnt <= next_cnt;
      per <= next_per;
      tag <= next_tag;
      lvl <= next_lvl;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

  assign out.lvl = lvl;
  assign out.rise = rise;
  assign out.fall = fall;
  assign out.tag = tag;
endmodule : mctc_div

// ---- verilog/mctc_chan.sv ----
// clock, sample strobe and bias of one converter core
// assumes the shared modulator clock arrives from a single divider
`timescale 1ns/1ps
module mctc_chan import mctc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // shared modulator clock
  mctc_clk_if.snk mod,
  // core outputs
  output logic mod_clk,
  output logic sample,
  output logic [1:0] bias
);
  logic next_mod_clk, next_sample;
  logic [1:0] next_bias;

  always_comb begin
    next_mod_clk = mod.lvl;
    next_sample = mod.rise || mod.fall;
    // bias moves with the period boundary that carried it
    next_bias = mod.rise ? mod.tag : bias;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_clk <= 1'b0;
      sample <= 1'b0;
      bias <= 2'h0;
    end else begin
      mod_clk <= next_mod_clk;
      sample <= next_sample;
      bias <= next_bias;
    end
  end
endmodule : mctc_chan

// ---- verilog/mctc_top.sv ----
// clock tree and power scaling control of the multichannel converter
// assumes all inputs are synchronous to the master clock CLK
//
// What this block does
// - every converter core is clocked from one shared divider of the one master clock.
// - the master clock source is one of logic clock, crystal pins or differential input.
// - modulator clock and output data clock are both derived from and synchronous to CLK.
// - each core samples twice per modulator clock period, on both of its edges.
// - the modulator clock is the master clock divided by 4, 8 or 32.
// - divider and power mode together set modulator clock rate and core bias.
// - one divider and one power mode serve all channels, none per channel.
// - in register mode power mode and divider are chosen independently.
// - in register mode power and divider sit at 0x04 and output clock rate at 0x07.
// - in pin mode power mode, modulator rate and output clock rate come from mode pins.
// - in pin mode the divider follows power: 32 low power, 8 median, 4 fast.
// - the output data clock is the master clock divided by 1, 2, 4 or 8; at 1 its level holds high and only the tick pulses.
// - the output data clock runs continuously, never gated to transfers.
`timescale 1ns/1ps
`include "mctc_map.svh"
module mctc_top import mctc_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // clock source straps and crystal pins
  input wire logic [1:0] CLK_SRC_SEL,
  input wire logic CRYSTAL_PIN_A,
  output logic CRYSTAL_PIN_B_O,
  output logic CRYSTAL_PIN_B_OE,
  output logic [1:0] CLK_SRC,
  // control mode and mode select pins
  input wire logic PIN_CTRL,
  input wire logic [3:0] MODE_SELECT_PINS,
  // register port from the serial control interface
  input wire logic REG_WR_EN,
  input wire logic REG_RD_EN,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RD_VALID,
  // digital filter decimation, as log2 of the ratio
  input wire logic [3:0] DECIM_LOG2,
  // converter core clocks
  output logic [`MCTC_NUM_CH-1:0] MOD_CLK,
  output logic [`MCTC_NUM_CH-1:0] SAMPLE_STROBE,
  output logic [2*`MCTC_NUM_CH-1:0] MOD_BIAS,
  // output data clock and rate strobes
  output logic DATA_OUTPUT_CLOCK,
  output logic DATA_CLK_TICK,
  output logic ODR_STROBE
);

  // ****************************************
  // clock source strap
  // ****************************************
  // the strap is caught in the first cycle after reset release, then frozen
  logic src_done, next_src_done;
  logic [1:0] src, next_src;
  logic xtal_b, next_xtal_b, xtal_oe, next_xtal_oe;

  always_comb begin
    next_src_done = 1'b1;
    next_src = src_done ? src : CLK_SRC_SEL;
    // source code 1 means crystal: keep the oscillator pin driven
    next_xtal_oe = (next_src == 2'h1);
    next_xtal_b = next_xtal_oe ? ~CRYSTAL_PIN_A : 1'b0;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      src_done <= 1'b0;
      src <= 2'h0;
      xtal_b <= 1'b0;
      xtal_oe <= 1'b0;
    end else begin
      src_done <= next_src_done;
      src <= next_src;
      xtal_b <= next_xtal_b;
      xtal_oe <= next_xtal_oe;
    end
  end

  assign CLK_SRC = src;
  assign CRYSTAL_PIN_B_O = xtal_b;
  assign CRYSTAL_PIN_B_OE = xtal_oe;

  // ****************************************
  // configuration registers
  // ****************************************
  logic [7:0] pwr_div_cfg, next_pwr_div_cfg;
  logic [7:0] out_clk_cfg, next_out_clk_cfg;
  logic [7:0] rdata, next_rdata;
  logic rd_valid, next_rd_valid;
  logic applied;

  always_comb begin
    next_pwr_div_cfg = pwr_div_cfg;
    next_out_clk_cfg = out_clk_cfg;
    if (REG_WR_EN && (REG_ADDR == `MCTC_REG_PWR_DIV)) begin
      next_pwr_div_cfg = REG_WDATA;
    end
    if (REG_WR_EN && (REG_ADDR == `MCTC_REG_OUT_CLK)) begin
      next_out_clk_cfg = REG_WDATA;
    end
    next_rd_valid = REG_RD_EN;
    next_rdata = 8'h00;
    if (REG_RD_EN) begin
      unique case (REG_ADDR)
        `MCTC_REG_PWR_DIV: next_rdata = pwr_div_cfg;
        `MCTC_REG_OUT_CLK: begin
          next_rdata = out_clk_cfg;
          next_rdata[`MCTC_APPLIED_BIT] = applied;
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwr_div_cfg <= `MCTC_PWR_DIV_RST;
      out_clk_cfg <= `MCTC_OUT_CLK_RST;
      rdata <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      pwr_div_cfg <= next_pwr_div_cfg;
      out_clk_cfg <= next_out_clk_cfg;
      rdata <= next_rdata;
      rd_valid <= next_rd_valid;
    end
  end

  assign REG_RDATA = rdata;
  assign REG_RD_VALID = rd_valid;

  // ****************************************
  // requested settings
  // ****************************************
  // range checks against the mode are left to the host: any pairing is accepted
  mctc_cfg_s req;
  mctc_per_t mod_per, out_per;
  logic [1:0] mod_tag;

  always_comb begin
    if (PIN_CTRL) begin
      req.pwr = mctc_pwr_e'(MODE_SELECT_PINS[1:0]);
      req.odiv = MODE_SELECT_PINS[3:2];
      unique case (req.pwr)
        MCTC_PWR_LOW: req.mdiv = 2'h0;
        MCTC_PWR_MED: req.mdiv = 2'h1;
        default: req.mdiv = 2'h2;
      endcase
    end else begin
      // power and divider fields decode on their own
      req.pwr = mctc_pwr_e'(pwr_div_cfg[`MCTC_PWR_MSB:`MCTC_PWR_LSB]);
      req.mdiv = pwr_div_cfg[`MCTC_MDIV_MSB:`MCTC_MDIV_LSB];
      req.odiv = out_clk_cfg[`MCTC_ODIV_MSB:`MCTC_ODIV_LSB];
    end
    unique case (req.mdiv)
      2'h0: mod_per = `MCTC_PER_DIV32;
      2'h1: mod_per = `MCTC_PER_DIV8;
      default: mod_per = `MCTC_PER_DIV4;
    endcase
    unique case (req.odiv)
      2'h0: out_per = `MCTC_PER_DIV1;
      2'h1: out_per = `MCTC_PER_DIV2;
      2'h2: out_per = `MCTC_PER_DIV4;
      default: out_per = `MCTC_PER_DIV8;
    endcase
    // reserved power code runs as fast
    mod_tag = (req.pwr == MCTC_PWR_RSVD) ? 2'(MCTC_PWR_FAST) : 2'(req.pwr);
  end

  // ****************************************
  // shared modulator clock and core clocks
  // ****************************************
  mctc_clk_if mod_if ();
  mctc_clk_if out_if ();

  // one divider for all cores, so every core sees the same edge
  mctc_div #(.RST_PER(`MCTC_PER_DIV32)) u_mod_div (
    .clk (CLK),
    .rst_n (RST_N),
    .per_in (mod_per),
    .tag_in (mod_tag),
    .out (mod_if.src)
  );

  genvar ch;
  generate
    for (ch = 0; ch < `MCTC_NUM_CH; ch = ch + 1) begin : g_chan
      mctc_chan u_chan (
        .clk (CLK),
        .rst_n (RST_N),
        .mod (mod_if.snk),
        .mod_clk (MOD_CLK[ch]),
        .sample (SAMPLE_STROBE[ch]),
        .bias (MOD_BIAS[2*ch+1:2*ch])
      );
    end
  endgenerate

  // ****************************************
  // output data clock
  // ****************************************
  // free running: it never waits on a transfer
  mctc_div #(.RST_PER(`MCTC_PER_DIV1)) u_out_div (
    .clk (CLK),
    .rst_n (RST_N),
    .per_in (out_per),
    .tag_in (req.odiv),
    .out (out_if.src)
  );

  assign DATA_OUTPUT_CLOCK = out_if.lvl;
  assign DATA_CLK_TICK = out_if.rise;

  // readback bit: output divider runs with the requested rate, modulator divider with the requested power tag
  assign applied = (mod_if.tag == mod_tag) && (out_if.tag == req.odiv);

  // ****************************************
  // output data rate strobe
  // ****************************************
  // ratio changes are taken at a frame boundary to keep channels framed alike
  logic [9:0] dec_cnt, next_dec_cnt;
  logic [9:0] dec_last, next_dec_last;
  logic [3:0] dec_log2;
  logic odr, next_odr;

  always_comb begin
    if (DECIM_LOG2 < `MCTC_DEC_MIN) begin
      dec_log2 = `MCTC_DEC_MIN;
    end else if (DECIM_LOG2 > `MCTC_DEC_MAX) begin
      dec_log2 = `MCTC_DEC_MAX;
    end else begin
      dec_log2 = DECIM_LOG2;
    end
    next_dec_cnt = dec_cnt;
    next_dec_last = dec_last;
    next_odr = 1'b0;
    if (mod_if.rise) begin
      if (dec_cnt >= dec_last) begin
        next_dec_cnt = 10'h000;
        next_dec_last = 10'((11'h001 << dec_log2) - 11'h001);
        next_odr = 1'b1;
      end else begin
        next_dec_cnt = 10'(dec_cnt + 10'h001);
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dec_cnt <= 10'h000;
      dec_last <= 10'h01F;
      odr <= 1'b0;
    end else begin
      dec_cnt <= next_dec_cnt;
      dec_last <= next_dec_last;
      odr <= next_odr;
    end
  end

  assign ODR_STROBE = odr;

endmodule : mctc_top

// ---- dv/mctc_properties.sv ----
// port-level assertions for the clock tree control
// assumes binding onto mctc_top, one clock domain CLK
`timescale 1ns/1ps
`include "mctc_map.svh"
module mctc_properties (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port
  input wire logic REG_RD_EN,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RD_VALID,
  // clock source
  input wire logic [1:0] CLK_SRC,
  input wire logic CRYSTAL_PIN_A,
  input wire logic CRYSTAL_PIN_B_O,
  input wire logic CRYSTAL_PIN_B_OE,
  // core clocks
  input wire logic [`MCTC_NUM_CH-1:0] MOD_CLK,
  input wire logic [`MCTC_NUM_CH-1:0] SAMPLE_STROBE,
  input wire logic [2*`MCTC_NUM_CH-1:0] MOD_BIAS
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // shortest divider is 4, so any level lasts two cycles
  sequence hold_high;
    MOD_CLK[0] [*2];
  endsequence
  sequence hold_low;
    !MOD_CLK[0] [*2];
  endsequence
  chk_rd_answer: assert property (REG_RD_EN |=> REG_RD_VALID)
    else $error("read not answered");
  chk_rd_quiet: assert property (!REG_RD_EN |=> !REG_RD_VALID && REG_RDATA == 8'h00)
    else $error("read data without read");
  chk_cores_same: assert property (MOD_CLK == {8{MOD_CLK[0]}})
    else $error("cores clocked apart");
  chk_bias_same: assert property (MOD_BIAS == {8{MOD_BIAS[1:0]}})
    else $error("bias differs per core");
  chk_mod_high: assert property ($rose(MOD_CLK[0]) |-> hold_high)
    else $error("modulator high too short");
  chk_mod_low: assert property ($fell(MOD_CLK[0]) |-> hold_low)
    else $error("modulator low too short");
  chk_sample_edges: assert property ($changed(MOD_CLK[0]) |-> SAMPLE_STROBE == 8'hFF)
    else $error("sample missed an edge");
  chk_bias_edge: assert property ($changed(MOD_BIAS) |-> $rose(MOD_CLK[0]))
    else $error("bias moved off boundary");
  chk_xtal_drive: assert property (CLK_SRC == 2'h1 |-> CRYSTAL_PIN_B_OE)
    else $error("crystal pin not driven");
  chk_xtal_inv: assert property (CRYSTAL_PIN_B_OE && $past(CRYSTAL_PIN_B_OE)
    |-> CRYSTAL_PIN_B_O == !$past(CRYSTAL_PIN_A))
    else $error("crystal feedback wrong");
endmodule : mctc_properties
bind mctc_top mctc_properties u_props (.CLK(CLK), .RST_N(RST_N), .REG_RD_EN(REG_RD_EN),
  .REG_RDATA(REG_RDATA), .REG_RD_VALID(REG_RD_VALID), .CLK_SRC(CLK_SRC),
  .CRYSTAL_PIN_A(CRYSTAL_PIN_A), .CRYSTAL_PIN_B_O(CRYSTAL_PIN_B_O),
  .CRYSTAL_PIN_B_OE(CRYSTAL_PIN_B_OE), .MOD_CLK(MOD_CLK),
  .SAMPLE_STROBE(SAMPLE_STROBE), .MOD_BIAS(MOD_BIAS));

// ---- dv/mctc_host.sv ----
// host model driving the register port of the clock tree control
// assumes fixed one-cycle read answer, inputs changed at falling edge
`timescale 1ns/1ps
module mctc_host (
  // clock
  input wire logic clk,
  // register port toward the block
  output logic wr_en,
  output logic rd_en,
  output logic [6:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rd_valid
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 7'h00;
    wdata = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
    // released data must not keep its last value
    wdata = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    addr = ~a;
    ok = rd_valid;
    d = rdata;
  endtask : rd
endmodule : mctc_host

// ---- dv/tb_modulator_clock_tree_control.sv ----
// self-checking bench: register model and measured clock periods
// assumes mctc_top with checker bound and host model on the register port
`timescale 1ns/1ps
module tb_modulator_clock_tree_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin_ctrl = 1'b0;
  logic xa = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [3:0] decim = 4'h5;
  logic [1:0] strap = 2'h1;
  logic wr_en, rd_en, rd_valid, xb_o, xb_oe, data_output_clock, tick, odr;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, mclk, smp;
  logic [1:0] src;
  logic [15:0] bias;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int mreg [int];
  int codes [$] = '{0, 1, 2, 3};
  int decs [$] = '{4, 6};
  int per;
  int p;
  int hi;
  always #5 clk = ~clk;
  always @(negedge clk) xa <= 1'($urandom_range(1, 0));
  mctc_host host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rd_valid(rd_valid));
  mctc_top dut (.CLK(clk), .RST_N(rst_n), .CLK_SRC_SEL(strap), .CRYSTAL_PIN_A(xa),
    .CRYSTAL_PIN_B_O(xb_o), .CRYSTAL_PIN_B_OE(xb_oe), .CLK_SRC(src), .PIN_CTRL(pin_ctrl),
    .MODE_SELECT_PINS(pins), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RD_VALID(rd_valid), .DECIM_LOG2(decim),
    .MOD_CLK(mclk), .SAMPLE_STROBE(smp), .MOD_BIAS(bias), .DATA_OUTPUT_CLOCK(data_output_clock),
    .DATA_CLK_TICK(tick), .ODR_STROBE(odr));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic wreg(input int a, input int d);
    host.wr(a[6:0], d[7:0]);
    if (a == 4 || a == 7) mreg[a] = d;
  endtask : wreg
  task automatic rdchk(input int a, input int mask);
    logic [7:0] v;
    logic ok;
    host.rd(a[6:0], v, ok);
    check(ok, 1'b1);
    check(v & mask[7:0], (mreg.exists(a) ? mreg[a] : 0) & mask);
  endtask : rdchk
  // cycles between the 3rd and 4th event; 0 if no 4th event is seen within 3000 cycles
  task automatic meas(input int sel, output int res);
    int n;
    int c;
    logic pv;
    logic ev;
    n = 0;
    c = 0;
    res = 0;
    pv = mclk[0];
    repeat (3000) begin
      @(negedge clk);
      c++;
      ev = sel == 0 ? mclk[0] & !pv : sel == 1 ? tick : odr;
      pv = mclk[0];
      if (ev === 1'b1) begin
        n++;
        if (n == 4) begin
          res = c;
          break;
        end
        c = 0;
      end
    end
  endtask : meas
  function automatic int mod_per(input int c);
    return c == 0 ? 32 : c == 1 ? 8 : 4;
  endfunction : mod_per
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(32'h5943));
    mreg[4] = 0;
    mreg[7] = 0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check(src, 2'h1);
    rdchk(4, 'hFF);
    rdchk(7, 'h7F);
    rdchk(5, 'hFF);
    foreach (codes[i]) begin
      p = $urandom_range(2, 0);
      wreg(4, p * 16 + codes[i]);
      rdchk(4, 'hFF);
      meas(0, per);
      check(per, mod_per(codes[i]));
      check(bias, {8{p[1:0]}});
      wreg(7, ($urandom_range(255, 0) & 'h80) | codes[i]);
      rdchk(7, 'h7F);
      meas(1, per);
      check(per, 1 << codes[i]);
      hi = 0;
      repeat (8) begin
        @(negedge clk);
        hi += data_output_clock;
      end
      check(hi, codes[i] == 0 ? 8 : 4);
    end
    foreach (decs[i]) begin
      decim = decs[i][3:0];
      meas(2, per);
      check(per, 4 << (decs[i] < 5 ? 5 : decs[i]));
    end
    pin_ctrl = 1'b1;
    foreach (codes[i]) begin
      // pins pair divider with power, as the recommended ranges want
      pins = {2'($urandom_range(3, 0)), codes[i][1:0]};
      meas(0, per);
      check(per, mod_per(codes[i]));
      check(bias, {8{(codes[i] < 3) ? codes[i][1:0] : 2'h2}});
      meas(1, per);
      check(per, 1 << pins[3:2]);
    end
    // strap is caught again after a mid-run reset
    strap = 2'h0;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check(src, 2'h0);
    check(xb_oe, 1'b0);
    complete_run();
  end
endmodule : tb_modulator_clock_tree_control
